// file: logic/cmac_pkg.sv
// shared types and constants for the cpu mode and address control block
package cmac_pkg;

  typedef enum logic [1:0] {
    CMAC_NORMAL = 2'h0,
    CMAC_MIDDLE = 2'h1,
    CMAC_ADVANCED = 2'h3,
    CMAC_MAXIMUM = 2'h2
  } cmac_mode_type;

  typedef enum logic [1:0] {
    CMAC_STK16 = 2'h0,
    CMAC_STK24 = 2'h1,
    CMAC_STK32 = 2'h2
  } cmac_stk_type;

  typedef enum logic [2:0] {
    CMAC_OP_ADDSUB = 3'h0,
    CMAC_OP_MUL32 = 3'h1,
    CMAC_OP_DIV16_8 = 3'h2,
    CMAC_OP_DIV32_16 = 3'h3,
    CMAC_OP_DIV32_32 = 3'h4
  } cmac_op_type;

  typedef enum logic [1:0] {
    CMAC_T_IDLE = 2'h0,
    CMAC_T_RUN = 2'h1,
    CMAC_T_DONE = 2'h3
  } cmac_tmr_state_type;

  localparam logic [31:0] CMAC_MASK_64K = 32'h0000FFFF;
  localparam logic [31:0] CMAC_MASK_16M = 32'h00FFFFFF;
  localparam logic [31:0] CMAC_MASK_4G = 32'hFFFFFFFF;
  localparam logic [31:0] CMAC_VEC_BASE = 32'h00000000;
  localparam int CMAC_SEXT_BIT = 15;
  localparam logic [1:0] CMAC_SHIFT_WORD = 2'h1;
  localparam logic [1:0] CMAC_SHIFT_LONG = 2'h2;

  localparam logic [4:0] CMAC_ST_ADDSUB = 5'h01;
  localparam logic [4:0] CMAC_ST_MUL32 = 5'h05;
  localparam logic [4:0] CMAC_ST_DIV16 = 5'h0A;
  localparam logic [4:0] CMAC_ST_DIV32 = 5'h12;

  localparam int CMAC_CCR_IMASK = 7;
  localparam logic [7:0] CMAC_CCR_RST = 8'h80;

endpackage : cmac_pkg

// file: logic/cmac_op_timer.sv
// state counter for register-to-register arithmetic latency
`timescale 1ns/10ps
module cmac_op_timer
  import cmac_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic op_start,
  input wire cmac_op_type op_kind,
  output logic op_busy_ff,
  output logic op_done_ff
);

  cmac_tmr_state_type state_ff;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic take;

  assign take = op_start && (state_ff == CMAC_T_IDLE);

  always_comb begin
    case (op_kind)
      CMAC_OP_ADDSUB: nxt_cnt = CMAC_ST_ADDSUB;
      CMAC_OP_MUL32: nxt_cnt = CMAC_ST_MUL32;
      CMAC_OP_DIV16_8: nxt_cnt = CMAC_ST_DIV16;
      default: nxt_cnt = CMAC_ST_DIV32;
    endcase
  end

  // R20 load state count
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= CMAC_T_IDLE;
      cnt_ff <= 5'h00;
      op_busy_ff <= 1'b0;
      op_done_ff <= 1'b0;
    end else begin
      case (state_ff)
        CMAC_T_IDLE: begin
          op_done_ff <= 1'b0;
          if (take) begin
            // the take edge is the first state, so only count-1 remain
            cnt_ff <= nxt_cnt - 5'h01;
            if (nxt_cnt == 5'h01) begin
              state_ff <= CMAC_T_DONE;
              op_done_ff <= 1'b1;
            end else begin
              state_ff <= CMAC_T_RUN;
              op_busy_ff <= 1'b1;
            end
          end
        end
        CMAC_T_RUN: begin
          cnt_ff <= cnt_ff - 5'h01;
          if (cnt_ff == 5'h01) begin
            state_ff <= CMAC_T_DONE;
            op_busy_ff <= 1'b0;
            op_done_ff <= 1'b1;
          end
        end
        CMAC_T_DONE: begin
          state_ff <= CMAC_T_IDLE;
          op_done_ff <= 1'b0;
        end
        default: begin
          state_ff <= CMAC_T_IDLE;
          op_busy_ff <= 1'b0;
          op_done_ff <= 1'b0;
        end
      endcase
    end
  end

  sequence add_req_s;
    take && op_kind == CMAC_OP_ADDSUB;
  endsequence
  sequence mul_req_s;
    take && op_kind == CMAC_OP_MUL32;
  endsequence
  sequence div16_req_s;
    take && op_kind == CMAC_OP_DIV16_8;
  endsequence
  sequence div32_req_s;
    take && (op_kind == CMAC_OP_DIV32_16 || op_kind == CMAC_OP_DIV32_32);
  endsequence

  add_lat_a: assert property (@(posedge clock) disable iff (!nrst) // R20
    add_req_s |=> op_done_ff) else $error("add/sub not done in one state");
  mul_lat_a: assert property (@(posedge clock) disable iff (!nrst) // R21
    mul_req_s |=> !op_done_ff [*4] ##1 op_done_ff) else $error("multiply not done in five states");
  div16_lat_a: assert property (@(posedge clock) disable iff (!nrst) // R22
    div16_req_s |=> op_busy_ff [*8] ##1 op_busy_ff ##1 op_done_ff) else $error("short divide not ten states");
  div32_lat_a: assert property (@(posedge clock) disable iff (!nrst) // R22
    div32_req_s |-> ##17 !op_done_ff ##1 op_done_ff) else $error("long divide not eighteen states");

endmodule : cmac_op_timer

// file: logic/cmac_mode_ctrl.sv
// operating mode, address shaping, vector, stack and fetch control of the cpu core
// Behaviour
// R1: normal mode limits every program and data address to 64 kilobytes.
// R2: middle mode data addresses keep low 16 bits, sign-extended into upper eight.
// R3: middle mode: 16 megabyte total, program up to 16M, data 64K.
// R4: normal mode vector table starts at zero, one 16-bit address per entry.
// R5: middle and advanced entries are 32 bits; low 24 bits are the target.
// R6: maximum mode vector table at zero, entries give full 32-bit target.
// R7: memory-indirect form reads location named by 8-bit absolute and branches there.
// R8: middle and advanced indirect operand is a longword, top byte taken as zero.
// R9: normal mode pushes and pops the program counter as 16 bits.
// R10: middle and advanced modes push and pop the program counter as 24 bits.
// R11: maximum mode pushes and pops the program counter as 32 bits.
// R12: maximum mode always saves and restores the extended control register.
// R13: upper half independent of address use, except carry or borrow propagates.
// R14: middle mode jumps and calls may use wider register contents.
// R15: advanced mode: 4 gigabyte space, program 16M, data 4G.
// R16: maximum mode: program and data both span the full 4 gigabytes.
// R17: fetch width select picks 16 or 32-bit fetch; data access unaffected.
// R18: software sets fetch width to match program memory bus width.
// R19: this variant runs only in advanced mode.
// R20: register add and subtract of 8, 16, 32 bits takes one state.
// R21: 32 by 32 multiply takes five states.
// R22: 16/8 divide takes ten states; 32/16 and 32/32 divides eighteen.
// R23: fetch ignores the program counter lsb and drives it as zero.
// R24: interrupt mask bit of condition flags set at every exception start.
// R25: mode sampled from a static strap after reset and held until next reset.
`timescale 1ns/10ps
module cmac_mode_ctrl
  import cmac_pkg::*;
#(
  parameter bit ONLY_ADVANCED = 1'b1
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] mode_strap,
  input wire logic fetch_width_select,
  input wire logic ea_valid,
  input wire logic ea_is_program,
  input wire logic [31:0] ea_in,
  input wire logic tbl_req_valid,
  input wire logic tbl_is_vector,
  input wire logic [7:0] tbl_index,
  input wire logic tbl_data_valid,
  input wire logic [31:0] tbl_data,
  input wire logic stk_valid,
  input wire logic [31:0] stk_value,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_pc,
  input wire logic upd_valid,
  input wire logic [31:0] upd_reg,
  input wire logic [2:0] upd_step,
  input wire logic upd_down,
  input wire logic cond_flags_write,
  input wire logic [7:0] cond_flags_wdata,
  input wire logic exc_start,
  input wire logic op_start,
  input wire cmac_op_type op_kind,
  output cmac_mode_type mode_ff,
  output logic mode_ready_ff,
  output logic mode_fault_ff,
  output logic addr_valid_ff,
  output logic [31:0] addr_out_ff,
  output logic addr_trunc_ff,
  output logic tbl_addr_valid_ff,
  output logic [31:0] tbl_addr_ff,
  output logic tbl_long_ff,
  output logic target_valid_ff,
  output logic [31:0] target_ff,
  output cmac_stk_type stk_width_ff,
  output logic exr_save_ff,
  output logic stk_out_valid_ff,
  output logic [31:0] stk_out_ff,
  output logic fetch_out_valid_ff,
  output logic [31:0] fetch_addr_ff,
  output logic fetch_long_ff,
  output logic upd_out_valid_ff,
  output logic [31:0] upd_result_ff,
  output logic [7:0] condition_flags_reg_ff,
  output logic op_busy_ff,
  output logic op_done_ff
);

  logic [31:0] nxt_addr;
  logic [31:0] nxt_fetch;
  logic [31:0] nxt_tbl_addr;
  logic [31:0] nxt_target;
  logic [31:0] nxt_stk;
  logic [31:0] nxt_upd;
  logic [31:0] step_ext;

  // address shaping per mode; program and data areas differ in middle and advanced modes
  function automatic logic [31:0] map_ea(input cmac_mode_type m, input logic prog, input logic [31:0] ea);
    logic [31:0] r;
    r = ea;
    case (m)
      CMAC_NORMAL: r = ea & CMAC_MASK_64K;
      CMAC_MIDDLE: begin
        if (prog) begin
          r = ea & CMAC_MASK_16M;
        end else begin
          r = {8'h00, {8{ea[CMAC_SEXT_BIT]}}, ea[15:0]};
        end
      end
      CMAC_ADVANCED: r = prog ? (ea & CMAC_MASK_16M) : (ea & CMAC_MASK_4G);
      CMAC_MAXIMUM: r = ea & CMAC_MASK_4G;
      default: r = ea;
    endcase
    return r;
  endfunction : map_ea

  // width of a stored branch address or stacked program counter
  function automatic logic [31:0] pc_mask(input cmac_mode_type m);
    logic [31:0] r;
    r = CMAC_MASK_4G;
    case (m)
      CMAC_NORMAL: r = CMAC_MASK_64K;
      CMAC_MIDDLE: r = CMAC_MASK_16M;
      CMAC_ADVANCED: r = CMAC_MASK_16M;
      default: r = CMAC_MASK_4G;
    endcase
    return r;
  endfunction : pc_mask

  // R25 catch strap once
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode_ff <= CMAC_ADVANCED;
      mode_ready_ff <= 1'b0;
      mode_fault_ff <= 1'b0;
    end else if (!mode_ready_ff) begin
      mode_ready_ff <= 1'b1;
      // R19 force advanced mode
      if (ONLY_ADVANCED) begin
        mode_ff <= CMAC_ADVANCED;
        mode_fault_ff <= (mode_strap != CMAC_ADVANCED);
      end else begin
        mode_ff <= cmac_mode_type'(mode_strap);
        mode_fault_ff <= 1'b0;
      end
    end
  end

  // R1 R2 R3 R14 R15 R16 effective address
  assign nxt_addr = map_ea(mode_ff, ea_is_program, ea_in);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      addr_valid_ff <= 1'b0;
      addr_out_ff <= 32'h00000000;
      addr_trunc_ff <= 1'b0;
    end else begin
      addr_valid_ff <= ea_valid;
      if (ea_valid) begin
        addr_out_ff <= nxt_addr;
        addr_trunc_ff <= (nxt_addr != ea_in);
      end
    end
  end

  // R4 R5 R6 R7 vector and indirect operand location
  always_comb begin
    if (tbl_is_vector) begin
      if (mode_ff == CMAC_NORMAL) begin
        nxt_tbl_addr = CMAC_VEC_BASE + ({24'h000000, tbl_index} << CMAC_SHIFT_WORD);
      end else begin
        nxt_tbl_addr = CMAC_VEC_BASE + ({24'h000000, tbl_index} << CMAC_SHIFT_LONG);
      end
    end else begin
      nxt_tbl_addr = {24'h000000, tbl_index};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tbl_addr_valid_ff <= 1'b0;
      tbl_addr_ff <= 32'h00000000;
      tbl_long_ff <= 1'b0;
    end else begin
      tbl_addr_valid_ff <= tbl_req_valid;
      if (tbl_req_valid) begin
        tbl_addr_ff <= nxt_tbl_addr;
        // R8 longword operand outside normal mode
        tbl_long_ff <= (mode_ff != CMAC_NORMAL);
      end
    end
  end

  // R5 R8 drop ignored upper bits of target
  assign nxt_target = tbl_data & pc_mask(mode_ff);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      target_valid_ff <= 1'b0;
      target_ff <= 32'h00000000;
    end else begin
      target_valid_ff <= tbl_data_valid;
      if (tbl_data_valid) begin
        target_ff <= nxt_target;
      end
    end
  end

  // R9 R10 R11 R12 stacking width and extended control save
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stk_width_ff <= CMAC_STK24;
      exr_save_ff <= 1'b0;
    end else begin
      case (mode_ff)
        CMAC_NORMAL: stk_width_ff <= CMAC_STK16;
        CMAC_MAXIMUM: stk_width_ff <= CMAC_STK32;
        default: stk_width_ff <= CMAC_STK24;
      endcase
      exr_save_ff <= (mode_ff == CMAC_MAXIMUM);
    end
  end

  assign nxt_stk = stk_value & pc_mask(mode_ff);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stk_out_valid_ff <= 1'b0;
      stk_out_ff <= 32'h00000000;
    end else begin
      stk_out_valid_ff <= stk_valid;
      if (stk_valid) begin
        stk_out_ff <= nxt_stk;
      end
    end
  end

  // R23 fetch address word aligned
  assign nxt_fetch = {map_ea(mode_ff, 1'b1, fetch_pc)} & 32'hFFFFFFFE;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fetch_out_valid_ff <= 1'b0;
      fetch_addr_ff <= 32'h00000000;
      fetch_long_ff <= 1'b0;
    end else begin
      fetch_out_valid_ff <= fetch_valid;
      if (fetch_valid) begin
        fetch_addr_ff <= nxt_fetch;
        // R17 fetch width only
        fetch_long_ff <= fetch_width_select;
      end
    end
  end

  // R13 carry and borrow reach upper half
  assign step_ext = {29'h00000000, upd_step};
  assign nxt_upd = upd_down ? (upd_reg - step_ext) : (upd_reg + step_ext);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      upd_out_valid_ff <= 1'b0;
      upd_result_ff <= 32'h00000000;
    end else begin
      upd_out_valid_ff <= upd_valid;
      if (upd_valid) begin
        upd_result_ff <= nxt_upd;
      end
    end
  end

  // R24 mask set wins over write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      condition_flags_reg_ff <= CMAC_CCR_RST;
    end else begin
      if (cond_flags_write) begin
        condition_flags_reg_ff <= cond_flags_wdata;
      end
      if (exc_start) begin
        condition_flags_reg_ff[CMAC_CCR_IMASK] <= 1'b1;
      end
    end
  end

  // R20 R21 R22 arithmetic state timing
  cmac_op_timer u_op_timer (
    .clock(clock),
    .nrst(nrst),
    .op_start(op_start),
    .op_kind(op_kind),
    .op_busy_ff(op_busy_ff),
    .op_done_ff(op_done_ff)
  );

  sequence vec_long_req_s;
    tbl_req_valid && tbl_is_vector && mode_ff != CMAC_NORMAL;
  endsequence
  sequence vec_word_req_s;
    tbl_req_valid && tbl_is_vector && mode_ff == CMAC_NORMAL;
  endsequence

  mode_hold_a: assert property (@(posedge clock) disable iff (!nrst) // R25
    mode_ready_ff |=> $stable(mode_ff) && mode_ready_ff) else $error("mode changed after capture");
  only_adv_a: assert property (@(posedge clock) disable iff (!nrst) // R19
    !ONLY_ADVANCED || mode_ff == CMAC_ADVANCED) else $error("unsupported mode in use");
  normal_space_a: assert property (@(posedge clock) disable iff (!nrst) // R1
    ea_valid && mode_ff == CMAC_NORMAL |=> addr_out_ff[31:16] == 16'h0000) else $error("normal address over 64K");
  mid_sext_a: assert property (@(posedge clock) disable iff (!nrst) // R2
    ea_valid && !ea_is_program && mode_ff == CMAC_MIDDLE
    |=> addr_out_ff[23:16] == {8{$past(ea_in[15])}} && addr_out_ff[15:0] == $past(ea_in[15:0]))
    else $error("middle data address not sign extended");
  adv_space_a: assert property (@(posedge clock) disable iff (!nrst) // R15
    ea_valid && mode_ff == CMAC_ADVANCED
    |=> addr_out_ff == ($past(ea_is_program) ? ($past(ea_in) & CMAC_MASK_16M) : $past(ea_in)))
    else $error("advanced area limit wrong");
  vec_long_a: assert property (@(posedge clock) disable iff (!nrst) // R5
    vec_long_req_s |=> tbl_long_ff && tbl_addr_ff == {22'h000000, $past(tbl_index), 2'h0})
    else $error("long vector entry address wrong");
  vec_word_a: assert property (@(posedge clock) disable iff (!nrst) // R4
    vec_word_req_s |=> !tbl_long_ff && tbl_addr_ff == {23'h000000, $past(tbl_index), 1'h0})
    else $error("word vector entry address wrong");
  tgt_mask_a: assert property (@(posedge clock) disable iff (!nrst) // R8
    tbl_data_valid && mode_ff == CMAC_ADVANCED |=> target_valid_ff && target_ff[31:24] == 8'h00)
    else $error("target upper byte not zero");
  stk_width_a: assert property (@(posedge clock) disable iff (!nrst) // R10
    stk_valid && mode_ff == CMAC_ADVANCED |=> stk_out_ff == ($past(stk_value) & CMAC_MASK_16M)
    && stk_width_ff == CMAC_STK24) else $error("stacked pc not 24 bits");
  exr_save_a: assert property (@(posedge clock) disable iff (!nrst) // R12
    ##1 exr_save_ff == ($past(mode_ff) == CMAC_MAXIMUM)) else $error("extended control save wrong");
  fetch_lsb_a: assert property (@(posedge clock) disable iff (!nrst) // R23
    fetch_valid |=> !fetch_addr_ff[0] && fetch_long_ff == $past(fetch_width_select))
    else $error("fetch address or width wrong");
  imask_set_a: assert property (@(posedge clock) disable iff (!nrst) // R24
    exc_start |=> condition_flags_reg_ff[CMAC_CCR_IMASK]) else $error("mask bit not set on exception");
  carry_prop_a: assert property (@(posedge clock) disable iff (!nrst) // R13
    upd_valid && !upd_down && upd_reg[15:0] == 16'hFFFF && upd_step != 3'h0
    |=> upd_result_ff[31:16] == $past(upd_reg[31:16]) + 16'h0001) else $error("carry lost to upper half");

endmodule : cmac_mode_ctrl

// file: sim/cmac_mode_ctrl_tb.sv
// self-checking testbench for the cpu mode and address control block
`timescale 1ns/10ps
module cmac_mode_ctrl_tb
  import cmac_pkg::*;
;
  localparam logic [31:0] ADR = 32'hA5F38ACE;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] mode_strap = 2'h3;
  logic fetch_width_select = 1'b0;
  logic ea_valid = 1'b0, ea_is_program = 1'b0, tbl_req_valid = 1'b0, tbl_is_vector = 1'b0, tbl_data_valid = 1'b0;
  logic stk_valid = 1'b0, fetch_valid = 1'b0, upd_valid = 1'b0, upd_down = 1'b0, cond_flags_write = 1'b0;
  logic exc_start = 1'b0, op_start = 1'b0;
  logic [31:0] ea_in = 32'h0, tbl_data = 32'h0, stk_value = 32'h0, fetch_pc = 32'h0, upd_reg = 32'h0;
  logic [7:0] tbl_index = 8'h0, cond_flags_wdata = 8'h0;
  logic [2:0] upd_step = 3'h1;
  cmac_op_type op_kind = CMAC_OP_ADDSUB;
  cmac_mode_type mode_ff;
  cmac_stk_type stk_width_ff;
  logic mode_ready_ff, mode_fault_ff, addr_valid_ff, addr_trunc_ff, tbl_addr_valid_ff, tbl_long_ff, target_valid_ff;
  logic exr_save_ff, stk_out_valid_ff, fetch_out_valid_ff, fetch_long_ff, upd_out_valid_ff, op_busy_ff, op_done_ff;
  logic [31:0] addr_out_ff, tbl_addr_ff, target_ff, stk_out_ff, fetch_addr_ff, upd_result_ff;
  logic [7:0] condition_flags_reg_ff;
  int err_total = 0;
  int n_compared = 0;

  cmac_mode_ctrl #(.ONLY_ADVANCED(1'b0)) i_cmac_mode_ctrl (
    .clock(clock), .nrst(nrst), .mode_strap(mode_strap), .fetch_width_select(fetch_width_select),
    .ea_valid(ea_valid), .ea_is_program(ea_is_program), .ea_in(ea_in), .tbl_req_valid(tbl_req_valid),
    .tbl_is_vector(tbl_is_vector), .tbl_index(tbl_index), .tbl_data_valid(tbl_data_valid), .tbl_data(tbl_data),
    .stk_valid(stk_valid), .stk_value(stk_value), .fetch_valid(fetch_valid), .fetch_pc(fetch_pc),
    .upd_valid(upd_valid), .upd_reg(upd_reg), .upd_step(upd_step), .upd_down(upd_down),
    .cond_flags_write(cond_flags_write), .cond_flags_wdata(cond_flags_wdata), .exc_start(exc_start),
    .op_start(op_start), .op_kind(op_kind), .mode_ff(mode_ff), .mode_ready_ff(mode_ready_ff),
    .mode_fault_ff(mode_fault_ff), .addr_valid_ff(addr_valid_ff), .addr_out_ff(addr_out_ff),
    .addr_trunc_ff(addr_trunc_ff), .tbl_addr_valid_ff(tbl_addr_valid_ff), .tbl_addr_ff(tbl_addr_ff),
    .tbl_long_ff(tbl_long_ff), .target_valid_ff(target_valid_ff), .target_ff(target_ff),
    .stk_width_ff(stk_width_ff), .exr_save_ff(exr_save_ff), .stk_out_valid_ff(stk_out_valid_ff),
    .stk_out_ff(stk_out_ff), .fetch_out_valid_ff(fetch_out_valid_ff), .fetch_addr_ff(fetch_addr_ff),
    .fetch_long_ff(fetch_long_ff), .upd_out_valid_ff(upd_out_valid_ff), .upd_result_ff(upd_result_ff),
    .condition_flags_reg_ff(condition_flags_reg_ff), .op_busy_ff(op_busy_ff), .op_done_ff(op_done_ff)
  );

  always #12.5 clock = ~clock;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] pmask(input cmac_mode_type m);
    pmask = (m == CMAC_NORMAL) ? CMAC_MASK_64K : (m == CMAC_MAXIMUM) ? CMAC_MASK_4G : CMAC_MASK_16M;
  endfunction : pmask

  function automatic logic [31:0] dmap(input cmac_mode_type m, input logic [31:0] a);
    if (m == CMAC_NORMAL) dmap = a & CMAC_MASK_64K;
    else if (m == CMAC_MIDDLE) dmap = {8'h00, {8{a[15]}}, a[15:0]};
    else dmap = a;
  endfunction : dmap

  task automatic do_reset(input cmac_mode_type m);
    nrst = 1'b0;
    mode_strap = m;
    repeat (5) @(negedge clock);
    chk(condition_flags_reg_ff, 32'h80, "flags in reset");
    chk(mode_ready_ff, 1'b0, "ready in reset");
    nrst = 1'b1;
    repeat (2) @(negedge clock);
    chk(mode_ff, m, "mode");
    chk(mode_ready_ff, 1'b1, "ready");
    chk(mode_fault_ff, 1'b0, "no fault");
  endtask : do_reset

  task automatic test_mode(input cmac_mode_type m);
    logic [31:0] pm;
    pm = pmask(m);
    do_reset(m);
    // strap moves after capture
    mode_strap = ~m;
    repeat (3) @(negedge clock);
    chk(mode_ff, m, "mode held");
    ea_valid = 1'b1; ea_in = ADR; tbl_req_valid = 1'b1; tbl_is_vector = 1'b1; tbl_index = 8'h0B;
    tbl_data_valid = 1'b1; tbl_data = ADR; stk_valid = 1'b1; stk_value = ADR; fetch_valid = 1'b1;
    fetch_pc = ADR | 32'h1; fetch_width_select = 1'b1;
    @(negedge clock);
    chk(addr_valid_ff, 1'b1, "ea valid");
    chk(addr_out_ff, dmap(m, ADR), "data ea");
    chk(addr_trunc_ff, dmap(m, ADR) != ADR, "trunc flag");
    chk(tbl_addr_ff, (m == CMAC_NORMAL) ? 32'h16 : 32'h2C, "vector addr");
    chk(tbl_long_ff, m != CMAC_NORMAL, "vector width");
    chk(target_valid_ff, 1'b1, "target valid");
    chk(target_ff, ADR & pm, "target");
    chk(stk_out_valid_ff, 1'b1, "stack valid");
    chk(stk_out_ff, ADR & pm, "stacked pc");
    chk(stk_width_ff, (m == CMAC_NORMAL) ? 0 : (m == CMAC_MAXIMUM) ? 2 : 1, "stack width");
    chk(exr_save_ff, m == CMAC_MAXIMUM, "exr save");
    chk(fetch_addr_ff, ADR & pm, "fetch addr");
    chk(fetch_long_ff, 1'b1, "fetch long");
    ea_is_program = 1'b1; tbl_is_vector = 1'b0; fetch_width_select = 1'b0;
    tbl_data_valid = 1'b0; stk_valid = 1'b0;
    @(negedge clock);
    chk(addr_out_ff, ADR & pm, "program ea");
    chk(tbl_addr_valid_ff, 1'b1, "indirect valid");
    chk(tbl_addr_ff, 32'h0B, "indirect addr");
    chk(tbl_long_ff, m != CMAC_NORMAL, "indirect width");
    chk(target_valid_ff, 1'b0, "target pulse");
    chk(stk_out_valid_ff, 1'b0, "stack pulse");
    chk(fetch_long_ff, 1'b0, "fetch word");
    chk(fetch_out_valid_ff, 1'b1, "fetch valid");
    ea_is_program = 1'b0; ea_in = 32'h12345678; tbl_req_valid = 1'b0; fetch_valid = 1'b0;
    @(negedge clock);
    ea_valid = 1'b0;
    chk(addr_out_ff, dmap(m, 32'h12345678), "data ea low");
    chk(fetch_out_valid_ff, 1'b0, "fetch pulse");
    @(negedge clock);
    chk(addr_valid_ff, 1'b0, "ea pulse");
    $display("test mode %0d done", m);
  endtask : test_mode

  task automatic test_upd_flags();
    upd_valid = 1'b1; upd_reg = 32'h0001FFFF; upd_step = 3'h1; upd_down = 1'b0;
    cond_flags_write = 1'b1; cond_flags_wdata = 8'h00;
    @(negedge clock);
    chk(upd_result_ff, 32'h00020000, "carry up");
    chk(upd_out_valid_ff, 1'b1, "upd valid");
    chk(condition_flags_reg_ff, 32'h00, "flags write");
    upd_reg = 32'h00010000; upd_step = 3'h2; upd_down = 1'b1; cond_flags_write = 1'b0; exc_start = 1'b1;
    @(negedge clock);
    chk(upd_result_ff, 32'h0000FFFE, "borrow down");
    chk(condition_flags_reg_ff, 32'h80, "exception mask");
    upd_valid = 1'b0; cond_flags_write = 1'b1;
    @(negedge clock);
    chk(upd_out_valid_ff, 1'b0, "upd pulse");
    chk(condition_flags_reg_ff[7], 1'b1, "mask wins");
    cond_flags_write = 1'b0; exc_start = 1'b0;
    $display("test update and flags done");
  endtask : test_upd_flags

  task automatic test_ops();
    cmac_op_type kinds[5] = '{CMAC_OP_ADDSUB, CMAC_OP_MUL32, CMAC_OP_DIV16_8, CMAC_OP_DIV32_16, CMAC_OP_DIV32_32};
    int lat[5] = '{1, 5, 10, 18, 18};
    int k;
    // each kind starts in the cycle after the previous done; the extra start at k == 2 lands while busy
    foreach (kinds[i]) begin
      op_kind = kinds[i];
      op_start = 1'b1;
      k = 1;
      @(negedge clock);
      op_start = 1'b0;
      while (op_done_ff !== 1'b1 && k < 40) begin
        chk(op_busy_ff, 1'b1, "busy");
        op_start = (k == 2);
        k++;
        @(negedge clock);
        op_start = 1'b0;
      end
      chk(k, lat[i], "latency");
      chk(op_busy_ff, 1'b0, "busy at done");
      @(negedge clock);
      chk(op_done_ff, 1'b0, "done pulse");
    end
    $display("test op timing done");
  endtask : test_ops

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    cmac_mode_type mlist[4] = '{CMAC_NORMAL, CMAC_MIDDLE, CMAC_ADVANCED, CMAC_MAXIMUM};
    @(negedge clock);
    foreach (mlist[i]) test_mode(mlist[i]);
    test_upd_flags();
    test_ops();
    wrap_up();
  end

  // watchdog: the tests need well under 1000 cycles
  initial begin
    #(5000 * 25);
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : cmac_mode_ctrl_tb
